/* File: design/cpm_pkg.sv */
package cpm_pkg;
   localparam int SAMPLE_W = 14;
   localparam int REG_W = 8;
   localparam int SER_ADDR_BITS = 8;
   localparam int SER_FRAME_BITS = 16;
   localparam int SYNC_W = 7;
   // bus byte offsets; serial address equals offset / 4
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_SWRESET = 4'h8;
   localparam logic [1:0] IDX_CTRL = 2'h0;
   localparam logic [1:0] IDX_STATUS = 2'h1;
   localparam logic [1:0] IDX_SWRESET = 2'h2;
   localparam int CTRL_READOUT_BIT = 0;
   localparam int CTRL_PDN_BIT = 1;
   localparam int SWRESET_BIT = 0;
   localparam logic CTRL_READOUT_RST = 1'h0;
   localparam logic CTRL_PDN_RST = 1'h0;
   localparam int ST_PARALLEL = 0;
   localparam int ST_PDN = 1;
   localparam int ST_EDGE = 2;
   localparam int ST_TWOS = 3;
   localparam int ST_CMOS = 4;
   localparam int ST_OE = 5;
   // format pin level code fields
   localparam int FMT_TWOS_BIT = 0;
   localparam int FMT_CMOS_BIT = 1;
   // synchroniser bank lanes
   localparam int SY_HWRST = 0;
   localparam int SY_SCLK = 1;
   localparam int SY_SERIAL_DATA_OR_POWERDOWN_PIN = 2;
   localparam int SY_SEN = 3;
   localparam int SY_FMT0 = 4;
   localparam int SY_FMT1 = 5;
   localparam int SY_OE = 6;
   typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_DATA, SER_DONE} cpm_ser_state_type;
endpackage

/* File: design/cpm_sync.sv */
`timescale 1ns/10ps
module cpm_sync #(parameter int WIDTH = 1) (
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [WIDTH-1:0] asyncIn, // levels from pins
   output logic [WIDTH-1:0] syncOut // synchronised levels
);
   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= asyncIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncOut = stage2_ff;
endmodule // cpm_sync

/* File: design/cpm_control_pin_mode.sv */
`timescale 1ns/10ps
module cpm_control_pin_mode (
   input wire logic clock, // 100 MHz system clock
   input wire logic rst, // async reset, active high
   input wire logic [3:0] regAddr, // register byte offset
   input wire logic [7:0] regWrData, // register write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   output logic [7:0] regRdData, // read data, cycle after strobe
   input wire logic hwResetPin, // hardware reset / mode pin
   input wire logic serialClkPin, // serial clock pin
   input wire logic serialDataOrPowerdownPin, // serial data or power-down
   input wire logic serialEnableOrEdgePin, // serial enable (low) or edge select
   input wire logic [1:0] formatSelectPin, // format pin level code
   input wire logic outputEnablePin, // output buffer enable, high
   input wire logic [13:0] sampleIn, // offset binary sample from core
   input wire logic sampleValid, // sample strobe from core
   input wire logic overRangeIn, // out-of-range flag from core
   output logic [13:0] parallelSampleBus, // CMOS data word
   output logic parallelSampleBusOe, // data bus drive enable
   output logic outputClockPin, // CMOS output clock
   output logic outputClockPinOe, // output clock drive enable
   output logic overrangeOrReadbackPin, // shared indicator / readback
   output logic overrangeOrReadbackPinOe, // shared pin drive enable
   output logic powerDown, // power-down request to core
   output logic parallelMode // high while pin-control mode
);
   logic [cpm_pkg::SYNC_W-1:0] pinSync;
   logic hwRstS, sclkS, sdataS, senS, twosS, cmosS, oeS;
   logic sclkDly_ff, nxt_sclkDly;
   logic sclkRise;
   cpm_pkg::cpm_ser_state_type serState_ff, nxt_serState;
   logic [4:0] bitCnt_ff, nxt_bitCnt;
   logic [cpm_pkg::SER_FRAME_BITS-1:0] shift_ff, nxt_shift;
   logic [cpm_pkg::REG_W-1:0] readShift_ff, nxt_readShift;
   logic readout_ff, nxt_readout;
   logic pdnBit_ff, nxt_pdnBit;
   logic [cpm_pkg::REG_W-1:0] rdData_ff, nxt_rdData;
   logic [13:0] sample_ff, nxt_sample;
   logic ovr_ff, nxt_ovr;
   logic clkDiv_ff, nxt_clkDiv;
   logic outClk_ff, nxt_outClk;
   logic sharedPin_ff, nxt_sharedPin;
   logic edgeSel;
   logic [cpm_pkg::SER_FRAME_BITS-1:0] frame;
   logic swResetReq;

   cpm_sync #(.WIDTH(cpm_pkg::SYNC_W)) u_sync (
      .clock(clock),
      .rst(rst),
      .asyncIn({outputEnablePin, formatSelectPin, serialEnableOrEdgePin, serialDataOrPowerdownPin,
                serialClkPin, hwResetPin}),
      .syncOut(pinSync)
   );

   assign hwRstS = pinSync[cpm_pkg::SY_HWRST];
   assign sclkS = pinSync[cpm_pkg::SY_SCLK];
   assign sdataS = pinSync[cpm_pkg::SY_SERIAL_DATA_OR_POWERDOWN_PIN];
   assign senS = pinSync[cpm_pkg::SY_SEN];
   assign twosS = pinSync[cpm_pkg::SY_FMT0 + cpm_pkg::FMT_TWOS_BIT];
   assign cmosS = pinSync[cpm_pkg::SY_FMT0 + cpm_pkg::FMT_CMOS_BIT];
   assign oeS = pinSync[cpm_pkg::SY_OE];

   // a held-high reset pin is the only thing that selects pin-control mode
   assign parallelMode = hwRstS;
   assign powerDown = parallelMode ? sdataS : pdnBit_ff;
   assign edgeSel = parallelMode ? senS : 1'b0;
   assign sclkRise = sclkS & ~sclkDly_ff;
   assign frame = {shift_ff[cpm_pkg::SER_FRAME_BITS-2:0], sdataS};

   function automatic logic [7:0] readIndex(input logic [1:0] idx);
      logic [7:0] val;
      val = 8'h00;
      case (idx)
         cpm_pkg::IDX_CTRL: begin
            val[cpm_pkg::CTRL_READOUT_BIT] = readout_ff;
            val[cpm_pkg::CTRL_PDN_BIT] = pdnBit_ff;
         end
         cpm_pkg::IDX_STATUS: begin
            val[cpm_pkg::ST_PARALLEL] = parallelMode;
            val[cpm_pkg::ST_PDN] = powerDown;
            val[cpm_pkg::ST_EDGE] = edgeSel;
            val[cpm_pkg::ST_TWOS] = twosS;
            val[cpm_pkg::ST_CMOS] = cmosS;
            val[cpm_pkg::ST_OE] = oeS;
         end
         default: val = 8'h00;
      endcase
      return val;
   endfunction

   // serial interface: 8 address bits then 8 data bits, msb first, enable low
   always_comb begin
      nxt_serState = serState_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_shift = shift_ff;
      nxt_readShift = readShift_ff;
      nxt_sclkDly = sclkS;
      nxt_readout = readout_ff;
      nxt_pdnBit = pdnBit_ff;
      swResetReq = 1'b0;
      if (regWr && regAddr == cpm_pkg::REG_CTRL) begin
         nxt_readout = regWrData[cpm_pkg::CTRL_READOUT_BIT];
         nxt_pdnBit = regWrData[cpm_pkg::CTRL_PDN_BIT];
      end
      if (regWr && regAddr == cpm_pkg::REG_SWRESET && regWrData[cpm_pkg::SWRESET_BIT]) begin
         swResetReq = 1'b1;
      end
      case (serState_ff)
         cpm_pkg::SER_IDLE: begin
            nxt_bitCnt = 5'h00;
            if (!senS && !parallelMode) begin
               nxt_serState = cpm_pkg::SER_ADDR;
            end
         end
         cpm_pkg::SER_ADDR: begin
            if (sclkRise) begin
               nxt_shift = frame;
               nxt_bitCnt = bitCnt_ff + 5'h01;
               if (bitCnt_ff == 5'(cpm_pkg::SER_ADDR_BITS - 1)) begin
                  nxt_serState = cpm_pkg::SER_DATA;
                  nxt_readShift = (frame[7:2] == 6'h00) ? readIndex(frame[1:0]) : 8'h00;
               end
            end
         end
         cpm_pkg::SER_DATA: begin
            if (sclkRise) begin
               nxt_shift = frame;
               nxt_bitCnt = bitCnt_ff + 5'h01;
               nxt_readShift = {readShift_ff[6:0], 1'b0};
               if (bitCnt_ff == 5'(cpm_pkg::SER_FRAME_BITS - 1)) begin
                  nxt_serState = cpm_pkg::SER_DONE;
                  // while readout is on, frames are reads and do not write
                  if (!readout_ff && frame[15:10] == 6'h00) begin
                     if (frame[9:8] == cpm_pkg::IDX_CTRL) begin
                        nxt_readout = frame[cpm_pkg::CTRL_READOUT_BIT];
                        nxt_pdnBit = frame[cpm_pkg::CTRL_PDN_BIT];
                     end
                     if (frame[9:8] == cpm_pkg::IDX_SWRESET && frame[cpm_pkg::SWRESET_BIT]) begin
                        swResetReq = 1'b1;
                     end
                  end
               end
            end
         end
         cpm_pkg::SER_DONE: nxt_serState = cpm_pkg::SER_DONE;
         default: nxt_serState = cpm_pkg::SER_IDLE;
      endcase
      // enable high aborts any frame
      if (senS || parallelMode) begin
         nxt_serState = cpm_pkg::SER_IDLE;
      end
      // a high reset pin or software reset returns the registers to defaults
      if (hwRstS || swResetReq) begin
         nxt_readout = cpm_pkg::CTRL_READOUT_RST;
         nxt_pdnBit = cpm_pkg::CTRL_PDN_RST;
      end
   end

   // bus read port and sample path
   always_comb begin
      nxt_rdData = 8'h00;
      if (regRd) begin
         nxt_rdData = (regAddr[1:0] == 2'h0) ? readIndex(regAddr[3:2]) : 8'h00;
      end
      nxt_sample = sample_ff;
      nxt_ovr = ovr_ff;
      if (sampleValid && !powerDown) begin
         nxt_sample = twosS ? {~sampleIn[13], sampleIn[12:0]} : sampleIn;
         nxt_ovr = overRangeIn;
      end
      nxt_clkDiv = (cmosS && !powerDown) ? ~clkDiv_ff : clkDiv_ff;
      nxt_outClk = clkDiv_ff ^ edgeSel;
      nxt_sharedPin = readout_ff ? readShift_ff[7] : ovr_ff;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         serState_ff <= cpm_pkg::SER_IDLE;
         bitCnt_ff <= 5'h00;
         shift_ff <= 16'h0000;
         readShift_ff <= 8'h00;
         sclkDly_ff <= 1'b0;
         readout_ff <= cpm_pkg::CTRL_READOUT_RST;
         pdnBit_ff <= cpm_pkg::CTRL_PDN_RST;
         rdData_ff <= 8'h00;
         sample_ff <= 14'h0000;
         ovr_ff <= 1'b0;
         clkDiv_ff <= 1'b0;
         outClk_ff <= 1'b0;
         sharedPin_ff <= 1'b0;
      end else begin
         serState_ff <= nxt_serState;
         bitCnt_ff <= nxt_bitCnt;
         shift_ff <= nxt_shift;
         readShift_ff <= nxt_readShift;
         sclkDly_ff <= nxt_sclkDly;
         readout_ff <= nxt_readout;
         pdnBit_ff <= nxt_pdnBit;
         rdData_ff <= nxt_rdData;
         sample_ff <= nxt_sample;
         ovr_ff <= nxt_ovr;
         clkDiv_ff <= nxt_clkDiv;
         outClk_ff <= nxt_outClk;
         sharedPin_ff <= nxt_sharedPin;
      end
   end

   assign regRdData = rdData_ff;
   assign parallelSampleBus = sample_ff;
   assign outputClockPin = outClk_ff;
   // the word bus is a CMOS-only driver; the LVDS pairs live elsewhere
   assign parallelSampleBusOe = oeS & cmosS;
   assign outputClockPinOe = oeS & cmosS;
   assign overrangeOrReadbackPinOe = oeS;
   assign overrangeOrReadbackPin = sharedPin_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_serData;
      (serState_ff == cpm_pkg::SER_ADDR && !senS && !parallelMode && sclkRise) |=> shift_ff[0] == $past(sdataS);
   endproperty
   a_serData: assert property (p_serData) else $error("serial bit not captured");
   property p_pdnPar;
      parallelMode |-> powerDown == sdataS;
   endproperty
   a_pdnPar: assert property (p_pdnPar) else $error("power-down not from data pin");
   property p_senIdle;
      (senS && !parallelMode) |=> serState_ff == cpm_pkg::SER_IDLE;
   endproperty
   a_senIdle: assert property (p_senIdle) else $error("frame active with enable high");
   property p_edge;
      parallelMode |=> outputClockPin == ($past(clkDiv_ff) ^ $past(senS));
   endproperty
   a_edge: assert property (p_edge) else $error("clock edge select wrong");
   property p_twos;
      (sampleValid && !powerDown && twosS) |=> parallelSampleBus[13] != $past(sampleIn[13]);
   endproperty
   a_twos: assert property (p_twos) else $error("two's complement msb wrong");
   property p_oe;
      !oeS |-> !parallelSampleBusOe && !outputClockPinOe && !overrangeOrReadbackPinOe;
   endproperty
   a_oe: assert property (p_oe) else $error("driver on with enable low");
   property p_oeOn;
      (oeS && cmosS) |-> parallelSampleBusOe;
   endproperty
   a_oeOn: assert property (p_oeOn) else $error("data bus off with enable high");
   property p_ovr;
      !readout_ff |=> overrangeOrReadbackPin == $past(ovr_ff);
   endproperty
   a_ovr: assert property (p_ovr) else $error("indicator not out-of-range");
   property p_readback;
      readout_ff |=> overrangeOrReadbackPin == $past(readShift_ff[7]);
   endproperty
   a_readback: assert property (p_readback) else $error("readback bit wrong");
   property p_word;
      (sampleValid && !powerDown && !twosS) |=> parallelSampleBus == $past(sampleIn);
   endproperty
   a_word: assert property (p_word) else $error("offset binary word wrong");
   property p_hwReset;
      hwRstS |=> !readout_ff && !pdnBit_ff;
   endproperty
   a_hwReset: assert property (p_hwReset) else $error("registers not reset by pin");
   c_parallel: cover property (parallelMode && cmosS && !powerDown);
   c_frameDone: cover property (serState_ff == cpm_pkg::SER_DATA ##1 serState_ff == cpm_pkg::SER_DONE);
   c_readback: cover property (readout_ff && overrangeOrReadbackPin);
endmodule // cpm_control_pin_mode

/* File: sim/cpm_ctrl_model.sv */
`timescale 1ns/10ps
module cpm_ctrl_model (
   input wire logic clock, // paces the pin changes
   input wire logic readbackPin, // shared indicator from device
   output logic hwResetPin, // mode / reset pin
   output logic serialClkPin, // serial clock, still between frames
   output logic dataPin, // serial data or power-down level
   output logic enablePin // serial enable or edge select
);
   initial begin
      hwResetPin = 1'h0;
      serialClkPin = 1'h0; // pull-down level while idle
      dataPin = 1'h0;
      enablePin = 1'h1; // pull-up level while idle
   end
   // this pulse returns the serial registers to their defaults
   task automatic init_pulse();
      @(posedge clock) hwResetPin <= 1'h1;
      repeat (6) @(posedge clock);
      hwResetPin <= 1'h0;
      repeat (6) @(posedge clock);
   endtask
   // pin-control mode lasts only while the reset pin stays high
   task automatic set_parallel(input logic pdn, input logic edgeSel);
      @(posedge clock) hwResetPin <= 1'h1;
      dataPin <= pdn;
      enablePin <= edgeSel;
   endtask
   // msb first, 4 cycles per clock phase; readback bits caught before rises 9 to 16
   task automatic frame(input logic [15:0] word, output logic [7:0] rb);
      @(posedge clock) enablePin <= 1'h0;
      for (int i = 15; i >= 0; i--) begin
         dataPin <= word[i];
         repeat (4) @(posedge clock);
         if (i < 8) rb[i] = readbackPin;
         serialClkPin <= 1'h1;
         repeat (4) @(posedge clock);
         serialClkPin <= 1'h0;
      end
      repeat (4) @(posedge clock);
      dataPin <= 1'h0;
      enablePin <= 1'h1;
      repeat (4) @(posedge clock);
   endtask
endmodule // cpm_ctrl_model

/* File: sim/control_pin_mode_select_tb.sv */
`timescale 1ns/10ps
module control_pin_mode_select_tb;
   logic clock, rst, regWr, regRd, hwResetPin, sclk, dataPin, enPin, oePin;
   logic sampleValid, overRangeIn, busOe, output_clock_pin, clkOe, shared, sharedOe, powerDown, parallelMode;
   logic [3:0] regAddr;
   logic [7:0] regWrData, regRdData, rd;
   logic [1:0] fmtPin;
   logic [13:0] sampleIn, busOut;
   logic prevClk;
   int bad_count, cmp_count;
   cpm_control_pin_mode DUT (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .hwResetPin(hwResetPin), .serialClkPin(sclk),
      .serialDataOrPowerdownPin(dataPin), .serialEnableOrEdgePin(enPin), .formatSelectPin(fmtPin),
      .outputEnablePin(oePin), .sampleIn(sampleIn), .sampleValid(sampleValid), .overRangeIn(overRangeIn),
      .parallelSampleBus(busOut), .parallelSampleBusOe(busOe), .outputClockPin(output_clock_pin),
      .outputClockPinOe(clkOe), .overrangeOrReadbackPin(shared), .overrangeOrReadbackPinOe(sharedOe),
      .powerDown(powerDown), .parallelMode(parallelMode));
   cpm_ctrl_model u_ctrl (.clock(clock), .readbackPin(shared), .hwResetPin(hwResetPin),
      .serialClkPin(sclk), .dataPin(dataPin), .enablePin(enPin));
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock) regWr <= 1'h1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock) regWr <= 1'h0;
   endtask
   task automatic chkReg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock) regRd <= 1'h1;
      regAddr <= a;
      @(posedge clock) regRd <= 1'h0;
      #1 chk(regRdData, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic t_regs();
      chkReg(4'h0, 8'h00);
      chkReg(4'hC, 8'h00);
      wr(4'h0, 8'h02);
      cyc(2);
      chk(powerDown, 1'h1);
      chkReg(4'h0, 8'h02);
      wr(4'h8, 8'h01);
      chkReg(4'h0, 8'h00);
   endtask
   task automatic t_serial();
      u_ctrl.init_pulse();
      u_ctrl.frame(16'h0001, rd);
      chkReg(4'h0, 8'h01);
      u_ctrl.frame(16'h0000, rd);
      chk(rd, 8'h01);
      wr(4'h8, 8'h01);
      chkReg(4'h0, 8'h00);
   endtask
   task automatic t_overrange();
      @(posedge clock) overRangeIn <= 1'h1;
      sampleValid <= 1'h1;
      @(posedge clock) sampleValid <= 1'h0;
      cyc(3);
      chk(shared, 1'h1);
      @(posedge clock) overRangeIn <= 1'h0;
      sampleValid <= 1'h1;
      @(posedge clock) sampleValid <= 1'h0;
      cyc(3);
      chk(shared, 1'h0);
   endtask
   task automatic t_parallel();
      u_ctrl.set_parallel(1'h1, 1'h1);
      cyc(5);
      chk({parallelMode, powerDown}, 2'h3);
      chkReg(4'h4, 8'h37);
      u_ctrl.set_parallel(1'h0, 1'h0);
      cyc(5);
      chk(powerDown, 1'h0);
      chkReg(4'h4, 8'h31);
   endtask
   task automatic t_format();
      for (int c = 0; c < 4; c++) begin
         @(posedge clock) fmtPin <= c[1:0];
         cyc(4);
         chkReg(4'h4, {3'h1, c[1:0], 3'h1});
         chk({busOe, clkOe, sharedOe}, {c[1], c[1], 1'h1});
      end
      @(posedge clock) oePin <= 1'h0;
      cyc(4);
      chk({busOe, clkOe, sharedOe}, 3'h0);
      @(posedge clock) oePin <= 1'h1;
      cyc(4);
   endtask
   task automatic t_sample(input logic [1:0] fmt, input logic [13:0] exp);
      @(posedge clock) fmtPin <= fmt;
      cyc(4);
      @(posedge clock) sampleValid <= 1'h1;
      sampleIn <= 14'h2ABC;
      @(posedge clock) sampleValid <= 1'h0;
      #1 chk(busOut, exp);
      prevClk = output_clock_pin;
      cyc(1);
      chk(output_clock_pin, !prevClk);
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
   initial begin
      rst = 1'h1;
      {regWr, regRd, sampleValid, overRangeIn} = 4'h0;
      regAddr = 4'h0;
      regWrData = 8'h00;
      fmtPin = 2'h2;
      oePin = 1'h1;
      sampleIn = 14'h0000;
      bad_count = 0;
      cmp_count = 0;
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      t_regs();
      t_serial();
      t_overrange();
      t_parallel();
      t_format();
      t_sample(2'h3, 14'h0ABC);
      t_sample(2'h2, 14'h2ABC);
      final_report();
   end
endmodule // control_pin_mode_select_tb
